// ==== verilog/rsc_pkg.sv ====
package rsc_pkg;

  // ************************************************************
  // register map (byte offsets, one 32-bit word each)
  // ************************************************************
  localparam logic [7:0] RSC_OFF_CTRL = 8'h00;
  localparam logic [7:0] RSC_OFF_THR = 8'h04;
  localparam logic [7:0] RSC_OFF_RXIRQ = 8'h08;
  localparam logic [7:0] RSC_OFF_TXBASE = 8'h0C;
  localparam logic [7:0] RSC_OFF_RXBASE = 8'h10;
  localparam logic [7:0] RSC_OFF_STATUS = 8'h14;
  localparam logic [7:0] RSC_OFF_ISTAT = 8'h18;
  localparam logic [7:0] RSC_OFF_ICLR = 8'h1C;
  localparam logic [7:0] RSC_OFF_IEN = 8'h20;
  localparam logic [7:0] RSC_OFF_TIMER = 8'h24;
  localparam logic [7:0] RSC_OFF_CMP = 8'h30;
  // one bit per word index, set where a register answers
  localparam logic [15:0] RSC_MAP = 16'hF3FF;

  localparam logic [1:0] RSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSC_RESP_SLVERR = 2'h2;

  // ************************************************************
  // sequence modes and reset values
  // ************************************************************
  localparam logic [2:0] RSC_MODE_RX = 3'h1;
  localparam logic [2:0] RSC_MODE_TX = 3'h2;
  localparam logic [2:0] RSC_MODE_CCA = 3'h3;
  localparam logic [2:0] RSC_MODE_TXRX = 3'h4;
  localparam logic [2:0] RSC_MODE_CCCA = 3'h5;

  localparam logic [3:0] RSC_THR_RST = 4'h8;

  // ************************************************************
  // interrupt status bit positions
  // ************************************************************
  localparam int RSC_IRQ_W = 8;
  localparam int RSC_IRQ_DONE = 0;
  localparam int RSC_IRQ_RXCNT = 1;
  localparam int RSC_IRQ_OVR = 2;
  localparam int RSC_IRQ_TMR = 4;

  localparam int RSC_TMR_N = 4;
  localparam int RSC_TMR_W = 24;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CCA, ST_LISTEN, ST_RX, ST_ACK_TX, ST_TX, ST_ACK_RX, ST_DONE
  } rsc_state_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic [3:0] cmp_en;
    logic tmr_start;
    logic abort;
    logic start;
    logic ack_exp;
    logic listen;
    logic [2:0] mode;
  } rsc_ctrl_t;

  typedef struct packed {
    logic [7:0] rsvd;
    logic [7:0] rx_cnt;
    logic [7:0] ed;
    logic [3:0] energy;
    logic cca_busy;
    logic [2:0] state;
  } rsc_status_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } rsc_dma_t;

endpackage : rsc_pkg

// ==== verilog/rsc_evt_cmp.sv ====
module rsc_evt_cmp #(
  parameter int W = 24
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [W-1:0] now_in,
  input wire logic [W-1:0] cmp_in,
  input wire logic en_in,
  output logic hit_out
);

  logic hit_q;
  wire match = en_in && (now_in == cmp_in);

  // one-cycle event when the running time reaches the compare value
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hit_q <= 1'b0;
    end else if (ce_in) begin
      hit_q <= match;
    end
  end

  assign hit_out = hit_q;

  a_cmp_hit: assert property (@(posedge clk_in) disable iff (rst_in || !ce_in)
    match |=> hit_q)
    else $error("compare match did not raise a hit");

endmodule : rsc_evt_cmp

// ==== verilog/rsc_top.sv ====
module rsc_top #(
  parameter int TMR_W = rsc_pkg::RSC_TMR_W
) (
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire logic CLK_EN_IN,
  // axi4-lite slave
  input wire logic [7:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [7:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  // modem, same clock
  input wire logic [7:0] MOD_RX_BYTE_IN,
  input wire logic MOD_RX_VALID_IN,
  input wire logic MOD_RX_END_IN,
  input wire logic MOD_ACK_REQ_IN,
  input wire logic MOD_TX_REQ_IN,
  input wire logic MOD_TX_END_IN,
  input wire logic MOD_CCA_DONE_IN,
  input wire logic MOD_CCA_BUSY_IN,
  input wire logic [7:0] MOD_ED_IN,
  output logic [7:0] MOD_TX_BYTE_OUT,
  output logic MOD_TX_VALID_OUT,
  // analog front end
  input wire logic [3:0] RF_ENERGY_IN,
  output logic RX_FULL_OUT,
  output logic RX_PARTIAL_OUT,
  output logic TX_EN_OUT,
  output logic CCA_EN_OUT,
  // cycle-steal ram port
  output logic DMA_REQ_OUT,
  output logic DMA_WE_OUT,
  output logic [15:0] DMA_ADDR_OUT,
  output logic [7:0] DMA_WDATA_OUT,
  input wire logic DMA_GRANT_IN,
  input wire logic [7:0] DMA_RDATA_IN,
  // interrupt
  output logic IRQ_OUT
);

  localparam int IW = rsc_pkg::RSC_IRQ_W;

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN || !CLK_EN_IN);

  // ************************************************************
  // register bus slave
  // ************************************************************
  logic aw_have_q, w_have_q, awrdy_q, wrdy_q, bvalid_q, arrdy_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, wdata_q;
  logic [3:0] wstrb_q;
  logic [7:0] waddr_q;
  logic [31:0] regs_v [16];

  wire aw_fire = S_AXI_AWVALID_IN && awrdy_q;
  wire w_fire = S_AXI_WVALID_IN && wrdy_q;
  wire ar_fire = S_AXI_ARVALID_IN && arrdy_q;
  wire b_done = bvalid_q && S_AXI_BREADY_IN;
  wire r_done = rvalid_q && S_AXI_RREADY_IN;
  wire wr_go = aw_have_q && w_have_q && !bvalid_q;
  wire [3:0] w_idx = waddr_q[5:2];
  wire [3:0] r_idx = S_AXI_ARADDR_IN[5:2];
  wire w_ok = (waddr_q[7:6] == 2'h0) && rsc_pkg::RSC_MAP[w_idx];
  wire r_ok = (S_AXI_ARADDR_IN[7:6] == 2'h0) && rsc_pkg::RSC_MAP[r_idx];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge

  wire [31:0] wval = merge(regs_v[w_idx], wdata_q, wstrb_q);
  wire wr_ctrl = wr_go && w_ok && (w_idx == rsc_pkg::RSC_OFF_CTRL[5:2]);
  wire wr_thr = wr_go && w_ok && (w_idx == rsc_pkg::RSC_OFF_THR[5:2]);
  wire wr_rxirq = wr_go && w_ok && (w_idx == rsc_pkg::RSC_OFF_RXIRQ[5:2]);
  wire wr_txb = wr_go && w_ok && (w_idx == rsc_pkg::RSC_OFF_TXBASE[5:2]);
  wire wr_rxb = wr_go && w_ok && (w_idx == rsc_pkg::RSC_OFF_RXBASE[5:2]);
  wire wr_iclr = wr_go && w_ok && (w_idx == rsc_pkg::RSC_OFF_ICLR[5:2]);
  wire wr_ien = wr_go && w_ok && (w_idx == rsc_pkg::RSC_OFF_IEN[5:2]);
  wire wr_cmp = wr_go && w_ok && (waddr_q[5:4] == rsc_pkg::RSC_OFF_CMP[5:4]);

  // each address channel closes until its response is taken
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awrdy_q <= 1'b1;
      wrdy_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= rsc_pkg::RSC_RESP_OKAY;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (CLK_EN_IN) begin
      if (aw_fire) begin
        aw_have_q <= 1'b1;
        awrdy_q <= 1'b0;
        waddr_q <= S_AXI_AWADDR_IN;
      end
      if (w_fire) begin
        w_have_q <= 1'b1;
        wrdy_q <= 1'b0;
        wdata_q <= S_AXI_WDATA_IN;
        wstrb_q <= S_AXI_WSTRB_IN;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= w_ok ? rsc_pkg::RSC_RESP_OKAY : rsc_pkg::RSC_RESP_SLVERR;
      end
      if (b_done) begin
        bvalid_q <= 1'b0;
        awrdy_q <= 1'b1;
        wrdy_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      arrdy_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= rsc_pkg::RSC_RESP_OKAY;
    end else if (CLK_EN_IN) begin
      if (ar_fire) begin
        arrdy_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= r_ok ? regs_v[r_idx] : '0;
        rresp_q <= r_ok ? rsc_pkg::RSC_RESP_OKAY : rsc_pkg::RSC_RESP_SLVERR;
      end else if (r_done) begin
        rvalid_q <= 1'b0;
        arrdy_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // software registers
  // ************************************************************
  rsc_pkg::rsc_ctrl_t ctrl_q;
  rsc_pkg::rsc_status_t status_v;
  logic [3:0] thr_q;
  logic [7:0] rxirq_q;
  logic [15:0] txbase_q, rxbase_q;
  logic [IW-1:0] ien_q, stat_q, stat_set;
  logic [TMR_W-1:0] now_q;
  logic [TMR_W-1:0] cmp_q [rsc_pkg::RSC_TMR_N];
  logic start_q, abort_q;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      ctrl_q <= '0;
      thr_q <= rsc_pkg::RSC_THR_RST;
      rxirq_q <= '0;
      txbase_q <= '0;
      rxbase_q <= '0;
      ien_q <= '0;
      start_q <= 1'b0;
      abort_q <= 1'b0;
      for (int i = 0; i < rsc_pkg::RSC_TMR_N; i++) cmp_q[i] <= '0;
    end else if (CLK_EN_IN) begin
      // start and abort are strobes and read back as zero
      start_q <= wr_ctrl && wval[5];
      abort_q <= wr_ctrl && wval[6];
      if (wr_ctrl) ctrl_q <= rsc_pkg::rsc_ctrl_t'(wval & 32'hFFFF_FF9F);
      if (wr_thr) thr_q <= wval[3:0];
      if (wr_rxirq) rxirq_q <= wval[7:0];
      if (wr_txb) txbase_q <= wval[15:0];
      if (wr_rxb) rxbase_q <= wval[15:0];
      if (wr_ien) ien_q <= wval[IW-1:0];
      if (wr_cmp) cmp_q[w_idx[1:0]] <= wval[TMR_W-1:0];
    end
  end

  // ************************************************************
  // event timer
  // ************************************************************
  logic [rsc_pkg::RSC_TMR_N-1:0] hit;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) now_q <= '0;
    else if (CLK_EN_IN) now_q <= now_q + 1'b1;
  end

  for (genvar g = 0; g < rsc_pkg::RSC_TMR_N; g++) begin : g_cmp
    rsc_evt_cmp #(.W(TMR_W)) u_cmp (
      .clk_in(SYS_CLK_IN),
      .rst_in(RESET_IN),
      .ce_in(CLK_EN_IN),
      .now_in(now_q),
      .cmp_in(cmp_q[g]),
      .en_in(ctrl_q.cmp_en[g]),
      .hit_out(hit[g])
    );
  end

  // ************************************************************
  // energy level from the analog side
  // ************************************************************
  logic [3:0] en_s1_q, en_s2_q, en_s3_q, energy_q;

  // a multi-bit level is only taken once two stages agree on it
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      en_s1_q <= '0;
      en_s2_q <= '0;
      en_s3_q <= '0;
      energy_q <= '0;
    end else if (CLK_EN_IN) begin
      en_s1_q <= RF_ENERGY_IN;
      en_s2_q <= en_s1_q;
      en_s3_q <= en_s2_q;
      if (en_s2_q == en_s3_q) energy_q <= en_s3_q;
    end
  end

  wire energy_ok = energy_q >= thr_q;

  // ************************************************************
  // sequencer
  // ************************************************************
  rsc_pkg::rsc_state_t st_q, st_d, rx_entry;
  logic cca_busy_q;
  logic [7:0] ed_q;

  wire [2:0] mode = ctrl_q.mode;
  wire go = start_q || (ctrl_q.tmr_start && hit[0]);
  assign rx_entry = ctrl_q.listen ? rsc_pkg::ST_LISTEN : rsc_pkg::ST_RX;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      rsc_pkg::ST_IDLE: begin
        if (go && mode == rsc_pkg::RSC_MODE_RX) st_d = rx_entry;
        else if (go && (mode == rsc_pkg::RSC_MODE_TX || mode == rsc_pkg::RSC_MODE_TXRX))
          st_d = rsc_pkg::ST_TX;
        else if (go && (mode == rsc_pkg::RSC_MODE_CCA || mode == rsc_pkg::RSC_MODE_CCCA))
          st_d = rsc_pkg::ST_CCA;
      end
      rsc_pkg::ST_CCA: begin
        // continuous assessment repeats while the channel reads busy
        if (MOD_CCA_DONE_IN)
          st_d = (mode == rsc_pkg::RSC_MODE_CCCA && MOD_CCA_BUSY_IN) ?
                 rsc_pkg::ST_CCA : rsc_pkg::ST_DONE;
      end
      rsc_pkg::ST_LISTEN: begin
        if (energy_ok) st_d = rsc_pkg::ST_RX;
      end
      rsc_pkg::ST_RX: begin
        if (MOD_RX_END_IN)
          st_d = (mode == rsc_pkg::RSC_MODE_RX && MOD_ACK_REQ_IN) ?
                 rsc_pkg::ST_ACK_TX : rsc_pkg::ST_DONE;
      end
      rsc_pkg::ST_ACK_TX: begin
        if (MOD_TX_END_IN) st_d = rsc_pkg::ST_DONE;
      end
      rsc_pkg::ST_TX: begin
        if (MOD_TX_END_IN && mode == rsc_pkg::RSC_MODE_TXRX)
          st_d = ctrl_q.ack_exp ? rsc_pkg::ST_ACK_RX : rx_entry;
        else if (MOD_TX_END_IN) st_d = rsc_pkg::ST_DONE;
      end
      rsc_pkg::ST_ACK_RX: begin
        if (MOD_RX_END_IN) st_d = rsc_pkg::ST_DONE;
      end
      rsc_pkg::ST_DONE: st_d = rsc_pkg::ST_IDLE;
    endcase
    if (abort_q && st_q != rsc_pkg::ST_IDLE) st_d = rsc_pkg::ST_DONE;
  end

  logic rx_full_q, rx_part_q, tx_en_q, cca_en_q;

  // power controls follow the next state so they line up with st_q
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      st_q <= rsc_pkg::ST_IDLE;
      rx_full_q <= 1'b0;
      rx_part_q <= 1'b0;
      tx_en_q <= 1'b0;
      cca_en_q <= 1'b0;
      cca_busy_q <= 1'b0;
      ed_q <= '0;
    end else if (CLK_EN_IN) begin
      st_q <= st_d;
      rx_full_q <= st_d == rsc_pkg::ST_RX || st_d == rsc_pkg::ST_ACK_RX;
      rx_part_q <= st_d == rsc_pkg::ST_LISTEN;
      tx_en_q <= st_d == rsc_pkg::ST_TX || st_d == rsc_pkg::ST_ACK_TX;
      cca_en_q <= st_d == rsc_pkg::ST_CCA;
      if (st_q == rsc_pkg::ST_CCA && MOD_CCA_DONE_IN) begin
        cca_busy_q <= MOD_CCA_BUSY_IN;
        ed_q <= MOD_ED_IN;
      end
    end
  end

  // ************************************************************
  // cycle-steal dma
  // ************************************************************
  rsc_pkg::rsc_dma_t dma_q;
  logic rd_pend_q, tx_vld_q;
  logic [7:0] tx_byte_q, tx_idx_q, rx_idx_q, rx_cnt_q;

  // frames are ignored in listen state, so weak ones never reach ram
  wire in_rx = st_q == rsc_pkg::ST_RX || st_q == rsc_pkg::ST_ACK_RX;
  wire rx_take = in_rx && MOD_RX_VALID_IN && !dma_q.req;
  wire rx_ovr = in_rx && MOD_RX_VALID_IN && dma_q.req;
  wire tx_fetch = st_q == rsc_pkg::ST_TX && MOD_TX_REQ_IN && !dma_q.req && !rd_pend_q;
  wire grant = DMA_GRANT_IN && dma_q.req;
  wire [7:0] rx_cnt_nx = rx_cnt_q + 8'h01;
  wire rx_cnt_hit = grant && dma_q.we && rx_cnt_nx == rxirq_q && rxirq_q != 8'h00;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      dma_q <= '0;
      rd_pend_q <= 1'b0;
      tx_vld_q <= 1'b0;
      tx_byte_q <= '0;
      tx_idx_q <= '0;
      rx_idx_q <= '0;
      rx_cnt_q <= '0;
    end else if (CLK_EN_IN) begin
      rd_pend_q <= grant && !dma_q.we;
      tx_vld_q <= rd_pend_q;
      if (rd_pend_q) tx_byte_q <= DMA_RDATA_IN;
      if (grant) dma_q.req <= 1'b0;
      if (grant && dma_q.we) rx_cnt_q <= rx_cnt_nx;
      if (rx_take) begin
        dma_q <= '{req: 1'b1, we: 1'b1, addr: rxbase_q + {8'h00, rx_idx_q},
                   wdata: MOD_RX_BYTE_IN};
        rx_idx_q <= rx_idx_q + 8'h01;
      end else if (tx_fetch) begin
        dma_q <= '{req: 1'b1, we: 1'b0, addr: txbase_q + {8'h00, tx_idx_q},
                   wdata: dma_q.wdata};
        tx_idx_q <= tx_idx_q + 8'h01;
      end
      if (st_q == rsc_pkg::ST_IDLE && go) begin
        tx_idx_q <= '0;
        rx_idx_q <= '0;
        rx_cnt_q <= '0;
      end
    end
  end

  // ************************************************************
  // interrupts and read view
  // ************************************************************
  logic irq_q;
  wire [IW-1:0] stat_clr = wr_iclr ? wval[IW-1:0] : '0;
  wire irq_any = |(stat_q & ien_q);

  always_comb begin
    stat_set = '0;
    stat_set[rsc_pkg::RSC_IRQ_DONE] = st_q == rsc_pkg::ST_DONE;
    stat_set[rsc_pkg::RSC_IRQ_RXCNT] = rx_cnt_hit;
    stat_set[rsc_pkg::RSC_IRQ_OVR] = rx_ovr;
    stat_set[rsc_pkg::RSC_IRQ_TMR +: rsc_pkg::RSC_TMR_N] = hit;
  end

  // a set arriving with its clear wins
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      stat_q <= '0;
      irq_q <= 1'b0;
    end else if (CLK_EN_IN) begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
      irq_q <= irq_any;
    end
  end

  assign status_v = '{rsvd: '0, rx_cnt: rx_cnt_q, ed: ed_q, energy: energy_q,
                      cca_busy: cca_busy_q, state: st_q};

  always_comb begin
    for (int i = 0; i < 16; i++) regs_v[i] = '0;
    regs_v[rsc_pkg::RSC_OFF_CTRL[5:2]] = ctrl_q;
    regs_v[rsc_pkg::RSC_OFF_THR[5:2]] = {28'h0000000, thr_q};
    regs_v[rsc_pkg::RSC_OFF_RXIRQ[5:2]] = {24'h000000, rxirq_q};
    regs_v[rsc_pkg::RSC_OFF_TXBASE[5:2]] = {16'h0000, txbase_q};
    regs_v[rsc_pkg::RSC_OFF_RXBASE[5:2]] = {16'h0000, rxbase_q};
    regs_v[rsc_pkg::RSC_OFF_STATUS[5:2]] = status_v;
    regs_v[rsc_pkg::RSC_OFF_ISTAT[5:2]] = 32'(stat_q);
    regs_v[rsc_pkg::RSC_OFF_IEN[5:2]] = 32'(ien_q);
    regs_v[rsc_pkg::RSC_OFF_TIMER[5:2]] = 32'(now_q);
    for (int i = 0; i < rsc_pkg::RSC_TMR_N; i++) begin
      regs_v[rsc_pkg::RSC_OFF_CMP[5:2] + i] = 32'(cmp_q[i]);
    end
  end

  assign S_AXI_AWREADY_OUT = awrdy_q;
  assign S_AXI_WREADY_OUT = wrdy_q;
  assign S_AXI_BVALID_OUT = bvalid_q;
  assign S_AXI_BRESP_OUT = bresp_q;
  assign S_AXI_ARREADY_OUT = arrdy_q;
  assign S_AXI_RVALID_OUT = rvalid_q;
  assign S_AXI_RDATA_OUT = rdata_q;
  assign S_AXI_RRESP_OUT = rresp_q;
  assign MOD_TX_BYTE_OUT = tx_byte_q;
  assign MOD_TX_VALID_OUT = tx_vld_q;
  assign RX_FULL_OUT = rx_full_q;
  assign RX_PARTIAL_OUT = rx_part_q;
  assign TX_EN_OUT = tx_en_q;
  assign CCA_EN_OUT = cca_en_q;
  assign DMA_REQ_OUT = dma_q.req;
  assign DMA_WE_OUT = dma_q.we;
  assign DMA_ADDR_OUT = dma_q.addr;
  assign DMA_WDATA_OUT = dma_q.wdata;
  assign IRQ_OUT = irq_q;

  // ************************************************************
  // checks
  // ************************************************************
  a_bus_write_resp: assert property (
    (w_fire && (aw_have_q || aw_fire)) |-> ##2 S_AXI_BVALID_OUT)
    else $error("write response late");
  a_bus_read_resp: assert property (
    ar_fire |=> S_AXI_RVALID_OUT && (S_AXI_RRESP_OUT == rsc_pkg::RSC_RESP_OKAY) == $past(r_ok))
    else $error("read answer wrong");
  a_tx_byte_path: assert property (
    (grant && !DMA_WE_OUT) |-> ##2 MOD_TX_VALID_OUT && MOD_TX_BYTE_OUT == $past(DMA_RDATA_IN))
    else $error("fetched byte not passed to modem");
  a_rx_byte_path: assert property (
    rx_take |=> DMA_REQ_OUT && DMA_WE_OUT && DMA_WDATA_OUT == $past(MOD_RX_BYTE_IN))
    else $error("received byte not queued to ram");
  a_rx_count_irq: assert property (
    rx_cnt_hit |=> stat_q[rsc_pkg::RSC_IRQ_RXCNT])
    else $error("byte count event missing");
  a_ack_follows: assert property (
    (st_q == rsc_pkg::ST_RX && MOD_RX_END_IN && !abort_q) |=>
      st_q == (($past(mode) == rsc_pkg::RSC_MODE_RX && $past(MOD_ACK_REQ_IN)) ?
               rsc_pkg::ST_ACK_TX : rsc_pkg::ST_DONE))
    else $error("wrong step after reception");
  a_txrx_to_rx: assert property (
    (st_q == rsc_pkg::ST_TX && MOD_TX_END_IN && mode == rsc_pkg::RSC_MODE_TXRX && !abort_q)
      |=> st_q inside {rsc_pkg::ST_RX, rsc_pkg::ST_LISTEN, rsc_pkg::ST_ACK_RX} ##1 !TX_EN_OUT)
    else $error("no receive after transmit");
  a_cca_repeat: assert property (
    (st_q == rsc_pkg::ST_CCA && MOD_CCA_DONE_IN && MOD_CCA_BUSY_IN &&
     mode == rsc_pkg::RSC_MODE_CCCA && !abort_q) |=> st_q == rsc_pkg::ST_CCA && CCA_EN_OUT)
    else $error("continuous assessment stopped");
  a_listen_power: assert property (
    st_q == rsc_pkg::ST_LISTEN |-> RX_PARTIAL_OUT && !RX_FULL_OUT)
    else $error("listen power wrong");
  a_listen_wake: assert property (
    (st_q == rsc_pkg::ST_LISTEN && energy_ok && !abort_q) |=>
      st_q == rsc_pkg::ST_RX && RX_FULL_OUT && !RX_PARTIAL_OUT)
    else $error("listen did not wake");
  a_below_level: assert property (
    (st_q == rsc_pkg::ST_LISTEN && !energy_ok && !abort_q) |=> st_q == rsc_pkg::ST_LISTEN)
    else $error("woke below threshold");
  a_done_flag: assert property (
    st_q == rsc_pkg::ST_DONE |=> stat_q[rsc_pkg::RSC_IRQ_DONE] && st_q == rsc_pkg::ST_IDLE)
    else $error("completion not flagged");
  a_irq_level: assert property (
    ##1 IRQ_OUT == |($past(stat_q) & $past(ien_q)))
    else $error("interrupt level wrong");

  c_rx_ack: cover property (st_q == rsc_pkg::ST_RX ##1 st_q == rsc_pkg::ST_ACK_TX);
  c_txrx: cover property (st_q == rsc_pkg::ST_TX ##1 st_q == rsc_pkg::ST_ACK_RX);
  c_listen_wake: cover property (st_q == rsc_pkg::ST_LISTEN ##1 st_q == rsc_pkg::ST_RX);
  c_rx_count: cover property (rx_cnt_hit);

endmodule : rsc_top

// ==== sim/rsc_far_end.sv ====
module rsc_far_end (
  // ram port
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic grant_out,
  output logic [7:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic cnt_q = 1'h0;
  initial grant_out = 1'h0;
  // grant only on odd cycles, so the steal path sees a slow ram
  always @(posedge clk_in) begin
    cnt_q <= ~cnt_q;
    grant_out <= req_in && !grant_out && cnt_q;
    if (req_in && grant_out && we_in) begin
      mem[addr_in[7:0]] <= wdata_in;
    end
    // stale data inverted, never held
    rdata_out <= (req_in && grant_out) ? mem[addr_in[7:0]] : ~rdata_out;
  end
endmodule : rsc_far_end

// ==== sim/radio_sequencer_ctrl_tb.sv ====
module radio_sequencer_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK_IN = 1'h0, RESET_IN = 1'h1, CLK_EN_IN = 1'h1;
  logic [7:0] S_AXI_AWADDR_IN = 8'h0, S_AXI_ARADDR_IN = 8'h0;
  logic [7:0] MOD_RX_BYTE_IN = 8'h0, MOD_ED_IN = 8'h0, DMA_RDATA_IN, MOD_TX_BYTE_OUT, DMA_WDATA_OUT;
  logic [31:0] S_AXI_WDATA_IN = 32'h0, S_AXI_RDATA_OUT, q, t;
  logic [3:0] S_AXI_WSTRB_IN = 4'hF, RF_ENERGY_IN = 4'h0;
  logic S_AXI_AWVALID_IN = 1'h0, S_AXI_WVALID_IN = 1'h0, S_AXI_BREADY_IN = 1'h0;
  logic S_AXI_ARVALID_IN = 1'h0, S_AXI_RREADY_IN = 1'h0, MOD_RX_VALID_IN = 1'h0;
  logic MOD_RX_END_IN = 1'h0, MOD_ACK_REQ_IN = 1'h0, MOD_TX_REQ_IN = 1'h0;
  logic MOD_TX_END_IN = 1'h0, MOD_CCA_DONE_IN = 1'h0, MOD_CCA_BUSY_IN = 1'h0;
  logic S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT;
  logic S_AXI_RVALID_OUT, MOD_TX_VALID_OUT, RX_FULL_OUT, RX_PARTIAL_OUT, TX_EN_OUT;
  logic CCA_EN_OUT, DMA_REQ_OUT, DMA_WE_OUT, IRQ_OUT, DMA_GRANT_IN;
  logic [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, r;
  logic [15:0] DMA_ADDR_OUT;
  logic [7:0] b [3];
  int mismatches = 0, comparisons = 0;
  always #5 SYS_CLK_IN = ~SYS_CLK_IN;
  rsc_top u_dut (.*);
  rsc_far_end u_far (.clk_in(SYS_CLK_IN), .req_in(DMA_REQ_OUT), .we_in(DMA_WE_OUT),
    .addr_in(DMA_ADDR_OUT), .wdata_in(DMA_WDATA_OUT), .grant_out(DMA_GRANT_IN),
    .rdata_out(DMA_RDATA_IN));
  // ************************************************************
  // helpers
  // ************************************************************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (e !== s) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task summarize;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  function logic [31:0] ctl(input logic [2:0] m, input logic l);
    return {26'h0, 1'h1, 1'h0, l, m};
  endfunction : ctl
  function logic sig(input int i);
    return i == 0 ? IRQ_OUT : i == 1 ? TX_EN_OUT : i == 2 ? RX_FULL_OUT : i == 3 ? RX_PARTIAL_OUT :
      i == 4 ? MOD_TX_VALID_OUT : CCA_EN_OUT;
  endfunction : sig
  // readies sampled at negedge: same value the next rising edge sees
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge SYS_CLK_IN);
    {S_AXI_AWADDR_IN, S_AXI_WDATA_IN} <= {a, d};
    {S_AXI_AWVALID_IN, S_AXI_WVALID_IN, S_AXI_BREADY_IN} <= 3'h7;
    tb = 1'h0;
    while (!tb) begin
      @(negedge SYS_CLK_IN);
      ta = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
      tw = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
      tb = S_AXI_BVALID_OUT === 1'h1;
      @(posedge SYS_CLK_IN);
      if (ta) S_AXI_AWVALID_IN <= 1'h0;
      if (tw) S_AXI_WVALID_IN <= 1'h0;
    end
    S_AXI_BREADY_IN <= 1'h0;
  endtask : wr
  task rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge SYS_CLK_IN);
    {S_AXI_ARADDR_IN, S_AXI_ARVALID_IN, S_AXI_RREADY_IN} <= {a, 2'h3};
    tr = 1'h0;
    while (!tr) begin
      @(negedge SYS_CLK_IN);
      ta = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
      tr = S_AXI_RVALID_OUT === 1'h1;
      {q, r} = {S_AXI_RDATA_OUT, S_AXI_RRESP_OUT};
      @(posedge SYS_CLK_IN);
      if (ta) S_AXI_ARVALID_IN <= 1'h0;
    end
    S_AXI_RREADY_IN <= 1'h0;
  endtask : rd
  task wt(input int i, input string nm);
    int n;
    n = 0;
    while (sig(i) !== 1'h1 && n < 80) begin
      @(negedge SYS_CLK_IN);
      n++;
    end
    chk(nm, 1, sig(i));
  endtask : wt
  task endp(input logic t);
    @(posedge SYS_CLK_IN);
    {MOD_TX_END_IN, MOD_RX_END_IN} <= {t, !t};
    @(posedge SYS_CLK_IN);
    {MOD_TX_END_IN, MOD_RX_END_IN} <= 2'h0;
  endtask : endp
  task cca(input logic y, input logic [7:0] e);
    @(posedge SYS_CLK_IN);
    {MOD_CCA_DONE_IN, MOD_CCA_BUSY_IN, MOD_ED_IN} <= {1'h1, y, e};
    @(posedge SYS_CLK_IN);
    MOD_CCA_DONE_IN <= 1'h0;
  endtask : cca
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    q = $urandom(32'hC1EA2769);
    repeat (20) @(posedge SYS_CLK_IN);
    RESET_IN <= 1'h0;
    rd(rsc_pkg::RSC_OFF_THR); chk("thr reset", rsc_pkg::RSC_THR_RST, q);
    rd(8'h28); chk("unmapped resp", rsc_pkg::RSC_RESP_SLVERR, r);
    wr(rsc_pkg::RSC_OFF_IEN, 3); wr(rsc_pkg::RSC_OFF_RXBASE, 32'h40); wr(rsc_pkg::RSC_OFF_RXIRQ, 2);
    wr(rsc_pkg::RSC_OFF_CTRL, ctl(rsc_pkg::RSC_MODE_RX, 1'h0));
    foreach (b[i]) begin
      b[i] = 8'($urandom);
      @(posedge SYS_CLK_IN);
      {MOD_RX_BYTE_IN, MOD_RX_VALID_IN} <= {b[i], 1'h1};
      @(posedge SYS_CLK_IN);
      MOD_RX_VALID_IN <= 1'h0;
      repeat (10) @(posedge SYS_CLK_IN);
      if (i == 0) @(negedge SYS_CLK_IN);
      if (i == 0) chk("early irq", 0, IRQ_OUT);
      if (i == 1) wt(0, "count irq");
      if (i == 1) wr(rsc_pkg::RSC_OFF_ICLR, 2);
    end
    MOD_ACK_REQ_IN <= 1'h1;
    endp(0); wt(1, "ack transmit");
    endp(1); wt(0, "done irq");
    rd(rsc_pkg::RSC_OFF_ISTAT); chk("done flag", 1, q);
    foreach (b[i]) chk("ram byte", b[i], u_far.mem[8'h40 + i]);
    wr(rsc_pkg::RSC_OFF_ICLR, 1); @(negedge SYS_CLK_IN); chk("irq clear", 0, IRQ_OUT);
    MOD_ACK_REQ_IN <= 1'h0;
    wr(rsc_pkg::RSC_OFF_CTRL, ctl(rsc_pkg::RSC_MODE_RX, 1'h1)); wt(3, "partial rx");
    RF_ENERGY_IN <= 4'h3; repeat (12) @(posedge SYS_CLK_IN);
    chk("below threshold", 0, RX_FULL_OUT);
    RF_ENERGY_IN <= 4'h9; wt(2, "full rx");
    endp(0); wt(0, "listen done"); chk("no ack", 0, TX_EN_OUT);
    wr(rsc_pkg::RSC_OFF_ICLR, 1); wr(rsc_pkg::RSC_OFF_CTRL, ctl(rsc_pkg::RSC_MODE_TXRX, 1'h0));
    wt(1, "tx on"); endp(1); wt(2, "rx after tx");
    wr(rsc_pkg::RSC_OFF_CTRL, 32'h40); wt(0, "abort done");
    wr(rsc_pkg::RSC_OFF_ICLR, 1); wr(rsc_pkg::RSC_OFF_TXBASE, 32'h40);
    wr(rsc_pkg::RSC_OFF_CTRL, ctl(rsc_pkg::RSC_MODE_TX, 1'h0));
    foreach (b[i]) begin
      @(posedge SYS_CLK_IN);
      MOD_TX_REQ_IN <= 1'h1;
      @(posedge SYS_CLK_IN);
      MOD_TX_REQ_IN <= 1'h0;
      wt(4, "tx valid"); chk("tx byte", b[i], MOD_TX_BYTE_OUT);
    end
    endp(1); wt(0, "tx done");
    wr(rsc_pkg::RSC_OFF_ICLR, 1); rd(rsc_pkg::RSC_OFF_TIMER); wr(rsc_pkg::RSC_OFF_CMP, q + 64);
    wr(rsc_pkg::RSC_OFF_CTRL, 32'h183); wt(5, "timer start");
    t = $urandom; cca(1'h1, t[7:0]); wt(0, "cca done");
    rd(rsc_pkg::RSC_OFF_STATUS); chk("cca status", {t[7:0], 4'h9, 1'h1}, q[15:3]);
    wr(rsc_pkg::RSC_OFF_ICLR, 1); wr(rsc_pkg::RSC_OFF_CTRL, ctl(rsc_pkg::RSC_MODE_CCCA, 1'h0));
    cca(1'h1, 8'h00); @(negedge SYS_CLK_IN); chk("cca repeat", 1, CCA_EN_OUT);
    cca(1'h0, 8'h00); wt(0, "ccca done");
    rd(rsc_pkg::RSC_OFF_TIMER); t = q; CLK_EN_IN <= 1'h0; repeat (10) @(posedge SYS_CLK_IN);
    CLK_EN_IN <= 1'h1; rd(rsc_pkg::RSC_OFF_TIMER); chk("timer freeze", 3, q - t);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge SYS_CLK_IN);
    mismatches++;
    summarize();
  end
endmodule : radio_sequencer_ctrl_tb
